// ### spi_flash_pkg.sv
/*
 * shared constants for the serial flash status-write and array-read logic:
 * command codes, status byte layout, frame bit counts, reset values, timing.
 * assumes a 100 MHz system clock and an spi mode 0 master.
 */
`default_nettype none

package spi_flash_pkg;

    // command codes
    localparam logic [7:0] OP_WRITE_UNLOCK  = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_STATUS_READ   = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
    localparam logic [7:0] OP_ARRAY_READ    = 8'h03;

    // status byte bit positions
    localparam int BIT_BUSY   = 0;
    localparam int BIT_WEL    = 1;
    localparam int BIT_BG_LO  = 2;
    localparam int BIT_BG_HI  = 3;
    localparam int BIT_LOCK   = 7;

    // frame bit counts
    localparam logic [5:0] LAST_OPCODE_BIT = 6'h07;
    localparam logic [5:0] LAST_DATA_BIT   = 6'h0f;
    localparam logic [5:0] FIRST_ADDR_BIT  = 6'h08;
    localparam logic [5:0] LAST_ADDR_BIT   = 6'h1f;
    localparam logic [5:0] OPCODE_LEN      = 6'h08;
    localparam logic [5:0] STATUS_WR_LEN   = 6'h10;
    localparam logic [5:0] COUNT_SAT       = 6'h3f;

    // delivery-state values of the retained bits
    localparam logic       LOCK_RST = 1'b0;
    localparam logic [1:0] BG_RST   = 2'h0;

    // self-timed status write cycle
    localparam int CLK_PERIOD_NS        = 10;
    localparam int STATUS_CYCLE_TIME_US = 5000;
    localparam int STATUS_CYCLE_CYCLES  = (STATUS_CYCLE_TIME_US * 1000) / CLK_PERIOD_NS;

    // array address width
    localparam int ARRAY_ADDR_W = 18;

    typedef enum logic {ST_IDLE, ST_CYCLE} wr_state_t;

endpackage

`default_nettype wire

// ### spi_flash_core.sv
/*
 * command logic of a serial flash: status write with self-timed cycle,
 * write latch, lock and guard bits, hardware-lock mode, status read and
 * sequential array read with wrap.
 * assumes an spi mode 0 master that clocks sck only while cs_n is low,
 * and an asynchronous array that presents rd_data within half an sck period
 * of rd_addr changing.
 */
// Operation
// - status write accepted only if write latch was set beforehand by unlock
// - status write never changes status bits 6,5,4,1,0
// - status bits 6,5,4 always read as zero
// - status write discarded unless chip select rises right after sixteenth bit
// - valid status write starts self-timed cycle on chip select rise
// - busy flag reads one during cycle, zero after completion
// - status reads keep working during the write cycle
// - write latch cleared before the write cycle finishes
// - status write updates both guard bits and may change lock bit
// - lock bit zero: status write with latch set accepted, any pin level
// - lock bit one, protect pin high: accepted if latch set
// - lock bit one, protect pin low: hardware lock, every status write rejected
// - in hardware lock the guarded array region is hardware protected
// - hardware lock entered whichever of lock bit and pin comes first; code enters it once both hold, i.e. on whichever comes last
// - hardware lock left only by raising the protect pin
// - array read is opcode plus three address bytes, sampled on rising sck
// - array data driven on falling sck edges after the address
// - read starts anywhere, address advances by one per byte
// - address wraps to zero past the top, streaming continues
// - chip select rise ends a read at any bit, output released
// - array read rejected while a write, program or erase cycle runs
// - address bits 23 to 18 ignored
// - all bytes travel most significant bit first
// - busy flag set during status write, program or erase cycles
// - write latch cleared at power-up and after disable or status write
`timescale 1ns/1ps
`default_nettype none

module spi_flash_core #(
    parameter int ADDR_W       = spi_flash_pkg::ARRAY_ADDR_W,
    parameter int CYCLE_CYCLES = spi_flash_pkg::STATUS_CYCLE_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              sck,
    input  wire logic              cs_n,
    input  wire logic              si,
    input  wire logic              wp_n,
    input  wire logic              array_busy,
    input  wire logic [7:0]        rd_data,
    output logic                   so,
    output logic                   so_oe,
    output logic [ADDR_W-1:0]      rd_addr,
    output logic                   busy_flag,
    output logic                   write_latch_flag,
    output logic                   status_lock_bit,
    output logic                   block_guard_hi,
    output logic                   block_guard_lo,
    output logic                   hardware_lock_mode
);
    import spi_flash_pkg::*;

    localparam int CW = $clog2(CYCLE_CYCLES + 1);

    // ------------------------------------------------------------
    // link domain (sck)
    // ------------------------------------------------------------
    logic              link_rst_n;
    logic              first_r;
    logic [5:0]        cnt_r;
    logic [5:0]        cnt_cur;
    logic [7:0]        shift_r;
    logic [7:0]        shift_nxt;
    logic [7:0]        opcode_r;
    logic [7:0]        data_r;
    logic [ADDR_W-1:0] addr_r;
    logic              phase_r;
    logic              mode_arr_r;
    logic [2:0]        dbit_r;
    logic              seq_tgl_r;
    logic [7:0]        st_q1_r;
    logic [7:0]        st_q2_r;
    logic [7:0]        st_q3_r;
    logic [7:0]        st_f_r;
    // status byte built on clk, read by the link-side synchroniser
    logic [7:0]        status_byte_r;
    logic [7:0]        out_byte;
    logic              so_r;
    logic              so_oe_r;

    // frame logic is cleared whenever the device is deselected
    assign link_rst_n = arst_n & ~cs_n;
    assign cnt_cur    = first_r ? 6'h00 : cnt_r;
    assign shift_nxt  = {shift_r[6:0], si};
    assign out_byte   = mode_arr_r ? rd_data : st_f_r;

    always_ff @(posedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    // bit count and captured fields survive deselect for the clk side
    always_ff @(posedge sck or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r     <= 6'h00;
            shift_r   <= 8'h00;
            opcode_r  <= 8'h00;
            data_r    <= 8'h00;
            seq_tgl_r <= 1'b0;
        end else begin
            shift_r <= shift_nxt;
            if (cnt_cur != COUNT_SAT) begin
                cnt_r <= cnt_cur + 6'h01;
            end
            if (first_r) begin
                seq_tgl_r <= ~seq_tgl_r;
            end
            if (cnt_cur == LAST_OPCODE_BIT) begin
                opcode_r <= shift_nxt;
            end
            if (cnt_cur == LAST_DATA_BIT) begin
                data_r <= shift_nxt;
            end
        end
    end

    // status byte into the link domain, three stages, change once 2nd and 3rd agree
    // stale between frames since sck stops; the opcode bits
    // give enough edges to bring it up to date before output
    always_ff @(posedge sck or negedge arst_n) begin
        if (!arst_n) begin
            st_q1_r <= 8'h00;
            st_q2_r <= 8'h00;
            st_q3_r <= 8'h00;
            st_f_r  <= 8'h00;
        end else begin
            st_q1_r <= status_byte_r;
            st_q2_r <= st_q1_r;
            st_q3_r <= st_q2_r;
            st_f_r  <= (st_q3_r & ~(st_q2_r ^ st_q3_r)) | (st_f_r & (st_q2_r ^ st_q3_r));
        end
    end

    // array address: 24 bits shifted through an ADDR_W register drop the top bits
    always_ff @(posedge sck or negedge arst_n) begin
        if (!arst_n) begin
            addr_r <= '0;
        end else if (opcode_r == OP_ARRAY_READ && cnt_cur >= FIRST_ADDR_BIT
                     && cnt_cur <= LAST_ADDR_BIT) begin
            addr_r <= {addr_r[ADDR_W-2:0], si};
        end else if (phase_r && mode_arr_r && dbit_r == 3'h7) begin
            addr_r <= addr_r + 1'b1;
        end
    end

    // data-out phase control
    // busy seen through the synchroniser; a read whose address
    // ends during a cycle never enables the output
    always_ff @(posedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            phase_r    <= 1'b0;
            mode_arr_r <= 1'b0;
            dbit_r     <= 3'h0;
        end else begin
            if (phase_r) begin
                dbit_r <= dbit_r + 3'h1;
            end
            if (cnt_cur == LAST_OPCODE_BIT && shift_nxt == OP_STATUS_READ) begin
                phase_r <= 1'b1;
            end
            if (cnt_cur == LAST_ADDR_BIT && opcode_r == OP_ARRAY_READ && !st_f_r[BIT_BUSY]) begin
                phase_r    <= 1'b1;
                mode_arr_r <= 1'b1;
            end
        end
    end

    // output bits change on falling sck, released on deselect
    always_ff @(negedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            so_r    <= 1'b0;
            so_oe_r <= 1'b0;
        end else begin
            so_oe_r <= phase_r;
            so_r    <= out_byte[~dbit_r];
        end
    end

    assign so      = so_r;
    assign so_oe   = so_oe_r;
    assign rd_addr = addr_r;

    // ------------------------------------------------------------
    // system domain (clk)
    // ------------------------------------------------------------
    logic [2:0]  cs_q_r;
    logic [2:0]  wp_q_r;
    logic [2:0]  seq_q_r;
    logic        cs_f_r;
    logic        wp_f_r;
    logic        seq_f_r;
    logic        seq_seen_r;
    logic        frame_end;
    logic        new_frame;
    logic        unlock_ok;
    logic        disable_ok;
    logic        swrite_ok;
    logic        hw_lock;
    logic        busy_all;
    logic        start_cycle;
    wr_state_t   state_r;
    logic [CW-1:0] cyc_cnt_r;
    logic [7:0]  pend_r;
    logic        wel_r;
    logic        lock_r;
    logic [1:0]  bg_r;
    logic        busy_r;
    logic        hw_lock_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cs_q_r  <= 3'h7;
            wp_q_r  <= 3'h7;
            seq_q_r <= 3'h0;
            cs_f_r  <= 1'b1;
            wp_f_r  <= 1'b1;
            seq_f_r <= 1'b0;
        end else begin
            cs_q_r  <= {cs_q_r[1:0], cs_n};
            wp_q_r  <= {wp_q_r[1:0], wp_n};
            seq_q_r <= {seq_q_r[1:0], seq_tgl_r};
            if (cs_q_r[1] == cs_q_r[2]) begin
                cs_f_r <= cs_q_r[2];
            end
            if (wp_q_r[1] == wp_q_r[2]) begin
                wp_f_r <= wp_q_r[2];
            end
            if (seq_q_r[1] == seq_q_r[2]) begin
                seq_f_r <= seq_q_r[2];
            end
        end
    end

    // link fields are static once cs_n has been seen high, so sampling is safe
    assign frame_end  = (cs_q_r[1] == cs_q_r[2]) && cs_q_r[2] && !cs_f_r;
    assign new_frame  = seq_f_r != seq_seen_r;
    assign unlock_ok  = opcode_r == OP_WRITE_UNLOCK && cnt_r == OPCODE_LEN;
    assign disable_ok = opcode_r == OP_WRITE_DISABLE && cnt_r == OPCODE_LEN;
    assign swrite_ok  = opcode_r == OP_STATUS_WRITE && cnt_r == STATUS_WR_LEN;
    assign hw_lock    = lock_r & ~wp_f_r;
    assign busy_all   = (state_r == ST_CYCLE) | array_busy;
    assign start_cycle = frame_end && new_frame && swrite_ok && wel_r && !busy_all
                         && !hw_lock;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seq_seen_r <= 1'b0;
        end else if (frame_end) begin
            seq_seen_r <= seq_f_r;
        end
    end

    // self-timed status write cycle, runs on clk only
    // independent of sck, so the master may stop clocking
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r   <= ST_IDLE;
            cyc_cnt_r <= '0;
            pend_r    <= 8'h00;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (start_cycle) begin
                        state_r   <= ST_CYCLE;
                        cyc_cnt_r <= CW'(CYCLE_CYCLES);
                        pend_r    <= data_r;
                    end
                end
                ST_CYCLE: begin
                    cyc_cnt_r <= cyc_cnt_r - 1'b1;
                    if (cyc_cnt_r == CW'(1)) begin
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // retained bits, committed as the cycle completes
    // guard bits from data bits 3 and 2, lock bit from data bit 7; others dropped
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lock_r <= LOCK_RST;
            bg_r   <= BG_RST;
        end else if (state_r == ST_CYCLE && cyc_cnt_r == CW'(1)) begin
            lock_r <= pend_r[BIT_LOCK];
            bg_r   <= {pend_r[BIT_BG_HI], pend_r[BIT_BG_LO]};
        end
    end

    // write latch; cleared as the cycle starts, well before it ends
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wel_r <= 1'b0;
        end else if (start_cycle) begin
            wel_r <= 1'b0;
        end else if (frame_end && new_frame && !busy_all) begin
            if (disable_ok) begin
                wel_r <= 1'b0;
            end else if (unlock_ok) begin
                wel_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_r        <= 1'b0;
            hw_lock_r     <= 1'b0;
            status_byte_r <= 8'h00;
        end else begin
            busy_r    <= busy_all;
            hw_lock_r <= hw_lock;
            status_byte_r <= {lock_r, 3'h0, bg_r, wel_r, busy_all};
        end
    end

    assign busy_flag          = busy_r;
    assign write_latch_flag   = wel_r;
    assign status_lock_bit    = lock_r;
    assign block_guard_hi     = bg_r[1];
    assign block_guard_lo     = bg_r[0];
    assign hardware_lock_mode = hw_lock_r;

endmodule

`default_nettype wire

// ### spi_flash_sva.sv
/* assertion checker for spi_flash_core, bound to every instance.
   assumes array_busy stays low while a status write cycle runs. */
`timescale 1ns/1ps
`default_nettype none
module spi_flash_sva #(
    parameter int CYCLE_CYCLES = 20
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic wp_n,
    input wire logic array_busy,
    input wire logic so_oe,
    input wire logic busy_flag,
    input wire logic write_latch_flag,
    input wire logic status_lock_bit,
    input wire logic block_guard_hi,
    input wire logic block_guard_lo,
    input wire logic hardware_lock_mode
);
    logic [31:0] cyc_cnt_r;
    logic        ab_seen_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            cyc_cnt_r <= 32'h0;
        else if (busy_flag)
            cyc_cnt_r <= cyc_cnt_r + 32'h1;
        else
            cyc_cnt_r <= 32'h0;
    end
    // busy spans caused by array_busy are not status cycles
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            ab_seen_r <= 1'b0;
        else if (array_busy)
            ab_seen_r <= 1'b1;
        else if (!busy_flag)
            ab_seen_r <= 1'b0;
    end
    sequence s_wr_start;
        $rose(busy_flag) && !$past(array_busy);
    endsequence
    property p_lock_enter;
        (status_lock_bit && !wp_n)[*6] |-> hardware_lock_mode;
    endproperty
    a_lock_enter: assert property (p_lock_enter) else $error("hardware lock not entered");
    property p_lock_exit;
        wp_n[*6] |-> !hardware_lock_mode;
    endproperty
    a_lock_exit: assert property (p_lock_exit) else $error("hardware lock held with pin high");
    property p_commit;
        $changed({status_lock_bit, block_guard_hi, block_guard_lo}) |-> $past(busy_flag);
    endproperty
    a_commit: assert property (p_commit) else $error("retained bits changed outside a cycle");
    property p_latch_before;
        s_wr_start |-> $past(write_latch_flag, 2);
    endproperty
    a_latch_before: assert property (p_latch_before) else $error("cycle started without latch");
    property p_latch_clear;
        s_wr_start |-> !write_latch_flag ##1 !write_latch_flag;
    endproperty
    a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared in cycle");
    property p_no_lock_write;
        s_wr_start |-> !$past(hardware_lock_mode, 2);
    endproperty
    a_no_lock_write: assert property (p_no_lock_write) else $error("status write ran in hardware lock");
    property p_cycle_len;
        $fell(busy_flag) && !ab_seen_r |-> cyc_cnt_r >= CYCLE_CYCLES && cyc_cnt_r <= CYCLE_CYCLES + 2;
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("status cycle length wrong");
    property p_cycle_max;
        busy_flag && !ab_seen_r |-> cyc_cnt_r <= CYCLE_CYCLES + 2;
    endproperty
    a_cycle_max: assert property (p_cycle_max) else $error("status cycle overran");
    property p_array_busy;
        array_busy |=> busy_flag;
    endproperty
    a_array_busy: assert property (p_array_busy) else $error("busy missing for array cycle");
    property p_release;
        cs_n |-> !so_oe;
    endproperty
    a_release: assert property (p_release) else $error("output driven while deselected");
    c_wr: cover property (s_wr_start);
    c_lock: cover property ($rose(hardware_lock_mode));
    c_read: cover property ($rose(so_oe));
endmodule
bind spi_flash_core spi_flash_sva #(.CYCLE_CYCLES(CYCLE_CYCLES)) chk_u (
    .clk, .arst_n, .cs_n, .wp_n, .array_busy, .so_oe, .busy_flag, .write_latch_flag,
    .status_lock_bit, .block_guard_hi, .block_guard_lo, .hardware_lock_mode
);
`default_nettype wire

// ### spi_master_model.sv
/* spi mode 0 bus master with byte tasks, 125 ns serial clock.
   assumes the caller sends whole bytes and ends each frame with stop. */
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
    output logic     sck,
    output logic     cs_n,
    output logic     si,
    input  wire logic so,
    input  wire logic so_oe
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
    end
    task automatic start();
        cs_n = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic oe);
        oe = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            si = tx[i];
            #62.5 sck = 1'b1;
            rx[i] = so;
            oe = oe | so_oe;
            #62.5 sck = 1'b0;
        end
    endtask
    task automatic stop();
        #62.5 cs_n = 1'b1;
        si = ~si;
        #400;
    endtask
endmodule
`default_nettype wire

// ### serial_flash_status_write_and_read_test.sv
/* self-checking bench for spi_flash_core driven through an spi master model.
   assumes a shortened status cycle and a synthetic array pattern. */
`timescale 1ns/1ps
`default_nettype none
module serial_flash_status_write_and_read_test;
    import spi_flash_pkg::*;
    logic clk, arst_n, wp_n, array_busy;
    wire logic sck, cs_n, si, so, so_oe, busy_flag, write_latch_flag;
    wire logic status_lock_bit, block_guard_hi, block_guard_lo, hardware_lock_mode;
    wire logic [17:0] rd_addr;
    wire logic [7:0] rd_data;
    int mismatches = 0;
    int num_checks = 0;
    function automatic logic [7:0] arr(input logic [17:0] a);
        return a[7:0] ^ {6'h00, a[17:16]} ^ 8'h5a;
    endfunction
    assign rd_data = arr(rd_addr);
    spi_flash_core #(.ADDR_W(18), .CYCLE_CYCLES(600)) dut_u (.clk(clk), .arst_n(arst_n), .sck(sck),
        .cs_n(cs_n), .si(si), .wp_n(wp_n), .array_busy(array_busy), .rd_data(rd_data), .so(so),
        .so_oe(so_oe), .rd_addr(rd_addr), .busy_flag(busy_flag), .write_latch_flag(write_latch_flag),
        .status_lock_bit(status_lock_bit), .block_guard_hi(block_guard_hi),
        .block_guard_lo(block_guard_lo), .hardware_lock_mode(hardware_lock_mode));
    spi_master_model mst_u (.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmd(input logic [7:0] op);
        logic [7:0] r;
        logic o;
        mst_u.start();
        mst_u.xfer(op, r, o);
        mst_u.stop();
    endtask
    task automatic rd_status(input logic [7:0] exp);
        logic [7:0] r;
        logic o;
        mst_u.start();
        mst_u.xfer(OP_STATUS_READ, r, o);
        mst_u.xfer(8'h00, r, o);
        mst_u.stop();
        chk("status", exp, r);
        chk("flags", exp, {status_lock_bit, 3'h0, block_guard_hi, block_guard_lo, write_latch_flag, busy_flag});
    endtask
    task automatic wr_status(input logic [7:0] d, input logic extra);
        logic [7:0] r;
        logic o;
        mst_u.start();
        mst_u.xfer(OP_STATUS_WRITE, r, o);
        mst_u.xfer(d, r, o);
        if (extra)
            mst_u.xfer(d, r, o);
        mst_u.stop();
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 1000 && busy_flag !== 1'b0; i++)
            @(posedge clk);
        chk("idle", 8'h00, {7'h00, busy_flag});
    endtask
    task automatic pin(input logic v);
        @(posedge clk);
        #1 wp_n = v;
        repeat (8) @(posedge clk);
    endtask
    task automatic array_rd(input logic [23:0] a, input int n, input logic exp_oe);
        logic [7:0] r;
        logic o;
        logic [17:0] p;
        p = a[17:0];
        mst_u.start();
        mst_u.xfer(OP_ARRAY_READ, r, o);
        for (int i = 2; i >= 0; i--)
            mst_u.xfer(a[i*8+:8], r, o);
        for (int i = 0; i < n; i++) begin
            mst_u.xfer(8'h00, r, o);
            chk("data_oe", {7'h00, exp_oe}, {7'h00, o});
            if (exp_oe)
                chk("array", arr(p), r);
            p = p + 18'h1;
        end
        mst_u.stop();
        chk("idle_oe", 8'h00, {7'h00, so_oe});
    endtask
    initial begin
        #500000;
        mismatches++;
        print_verdict();
    end
    initial begin
        arst_n = 1'b0;
        wp_n = 1'b1;
        array_busy = 1'b0;
        repeat (16) @(posedge clk);
        #1 arst_n = 1'b1;
        repeat (4) @(posedge clk);
        rd_status(8'h00);
        wr_status(8'h8c, 1'b0);
        rd_status(8'h00);
        cmd(OP_WRITE_UNLOCK);
        rd_status(8'h02);
        wr_status(8'hff, 1'b0);
        rd_status(8'h01);
        wait_idle();
        rd_status(8'h8c);
        cmd(OP_WRITE_UNLOCK);
        wr_status(8'h00, 1'b1);
        rd_status(8'h8e);
        cmd(OP_WRITE_DISABLE);
        rd_status(8'h8c);
        pin(1'b0);
        chk("hw_lock", 8'h01, {7'h00, hardware_lock_mode});
        cmd(OP_WRITE_UNLOCK);
        wr_status(8'h00, 1'b0);
        rd_status(8'h8e);
        pin(1'b1);
        chk("hw_lock", 8'h00, {7'h00, hardware_lock_mode});
        wr_status(8'h00, 1'b0);
        wait_idle();
        rd_status(8'h00);
        pin(1'b0);
        chk("hw_lock", 8'h00, {7'h00, hardware_lock_mode});
        cmd(OP_WRITE_UNLOCK);
        wr_status(8'h80, 1'b0);
        wait_idle();
        rd_status(8'h80);
        chk("hw_lock", 8'h01, {7'h00, hardware_lock_mode});
        pin(1'b1);
        array_rd(24'hfffffe, 4, 1'b1);
        @(posedge clk);
        #1 array_busy = 1'b1;
        rd_status(8'h81);
        array_rd(24'h000010, 1, 1'b0);
        @(posedge clk);
        #1 array_busy = 1'b0;
        wait_idle();
        rd_status(8'h80);
        print_verdict();
    end
endmodule
`default_nettype wire
